// [port_cfg_pkg.sv]
// shared constants for the eight-pin port configuration block
package port_cfg_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int PIN_COUNT = 8;
   localparam int ADDR_WIDTH = 10;
   localparam int DATA_WIDTH = 32;
   // ****************************************
   // register indices (byte address is four times the index)
   // ****************************************
   localparam logic [9:0] IDX_DIRECTION = 10'h282;
   localparam logic [9:0] IDX_PULL_ENABLE = 10'h283;
   localparam logic [9:0] IDX_PULL_POLARITY = 10'h284;
   localparam logic [9:0] IDX_WIRED_OR = 10'h285;
   localparam logic [9:0] IDX_PORT_DATA = 10'h286;
   localparam logic [9:0] IDX_PORT_INPUT = 10'h287;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h288;
   localparam logic [9:0] IDX_IRQ_CLEAR = 10'h289;
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h28A;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_PULL_ENABLE = 8'hFF;
   localparam logic [7:0] RST_PULL_POLARITY = 8'h00;
   localparam logic [7:0] RST_WIRED_OR = 8'h00;
   localparam logic [7:0] RST_PORT_DATA = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   // ****************************************
   // pin groups sharing peripherals
   // ****************************************
   localparam int LCD_PIN_LO = 4;
   localparam int I2C_SDA_PIN = 5;
   localparam int I2C_SCL_PIN = 6;
   localparam int TIMB_PIN_LO = 2;
   localparam int CAN_TX_PIN = 1;
   localparam int CAN_RX_PIN = 0;
   // ****************************************
   // timing: read-back settles within this many bus clocks
   // ****************************************
   localparam int SETTLE_CYCLES = 2;
endpackage

// [port_pin_mux.sv]
// per-pin resolution of programmed direction against peripheral overrides
module port_pin_mux (
   // programmed configuration
   input wire logic [7:0] dir_bits,
   input wire logic [7:0] data_bits,
   input wire logic [7:0] pull_en_bits,
   input wire logic [7:0] wired_or_bits,
   // peripheral enables and data
   input wire logic lcd_enable,
   input wire logic i2c_active,
   input wire logic [1:0] i2c_out,
   input wire logic [1:0] timb_oc_active,
   input wire logic [1:0] timb_oc_out,
   input wire logic [1:0] tima_oc_active,
   input wire logic [1:0] tima_oc_out,
   input wire logic can_active,
   input wire logic can_tx,
   // resolved pad controls
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output logic [7:0] pad_ibuf_en,
   output logic [7:0] pad_pull_on
);
   import port_cfg_pkg::*;

   logic [7:0] force_out;
   logic [7:0] force_in;
   logic [7:0] force_od;
   logic [7:0] periph_data;
   logic [7:0] off;

   // overrides only steer the pads; dir_bits itself is never touched
   assign off = {{4{lcd_enable}}, 4'h0}; // R2 R19
   assign force_out[7] = 1'b0;
   assign force_out[4] = 1'b0;
   assign force_out[6:5] = {2{i2c_active & ~lcd_enable}}; // R3
   assign force_od = {1'b0, force_out[6:5], 5'h00}; // R3
   assign force_out[3:2] = timb_oc_active; // R4
   assign force_out[1] = tima_oc_active[1] | can_active; // R5
   assign force_out[0] = tima_oc_active[0]; // R6
   assign force_in = {7'h00, ~tima_oc_active[0] & can_active}; // R6
   assign periph_data = {1'b0, i2c_out, 1'b0, timb_oc_out,
                         tima_oc_active[1] ? tima_oc_out[1] : can_tx, tima_oc_out[0]};

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_pin
         logic drive;
         logic val;
         logic od;
         assign drive = ~off[i] & (force_out[i] | (dir_bits[i] & ~force_in[i])); // R1
         assign val = force_out[i] ? periph_data[i] : data_bits[i];
         // wired-or only matters once the pin drives
         assign od = force_od[i] | wired_or_bits[i]; // R12 R13
         assign pad_out[i] = od ? 1'b0 : val; // R12
         assign pad_oe[i] = drive & ~(od & val); // R12
         assign pad_ibuf_en[i] = ~off[i]; // R2
         assign pad_pull_on[i] = pull_en_bits[i] & ~drive & ~off[i]; // R8
      end
   endgenerate
endmodule

// [port_edge_flags.sv]
// sticky per-pin edge flags with write-one-to-clear
module port_edge_flags (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] pin_now,
   input wire logic [7:0] polarity_bits,
   input wire logic [7:0] clear_bits,
   output logic [7:0] flags
);
   import port_cfg_pkg::*;

   logic [7:0] pin_prev_reg;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] hit;

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_edge
         // polarity 1 picks rising edges, 0 picks falling
         assign hit[i] = polarity_bits[i] ? (pin_now[i] & ~pin_prev_reg[i])
                                          : (~pin_now[i] & pin_prev_reg[i]); // R10 R11
      end
   endgenerate

   // a new edge beats a clear arriving in the same cycle
   assign flags_next = (flags_reg & ~clear_bits) | hit; // R18
   assign flags = flags_reg;

   always_ff @(posedge clock) begin
      if (reset) begin
         pin_prev_reg <= 8'h00;
         flags_reg <= 8'h00;
      end else begin
         pin_prev_reg <= pin_now;
         flags_reg <= flags_next;
      end
   end
endmodule

// [port_r_pin_config.sv]
// register file, pad control and interrupt for the eight-pin port
// Function
// [R1] direction bit 1 drives pin as output, 0 makes it input, absent overrides
// [R2] lcd enabled disables input and output buffers on pins 7 to 4
// [R3] pins 6,5: without lcd, active i2c forces open-drain output
// [R4] pins 3,2: second timer compare routed and enabled forces output
// [R5] pin 1: first timer compare forces output, else active can transmit does
// [R6] pin 0: timer compare forces output, else active can receive forces input
// [R7] after direction change, data and input reads settle within two clocks
// [R8] pull-enable acts only while pin is an input
// [R9] all pull devices enabled after reset
// [R10] polarity 1: pull-down, rising edge sets the pin flag
// [R11] polarity 0: pull-up, falling edge sets the pin flag
// [R12] wired-or 1 makes output open-drain, 0 push-pull
// [R13] wired-or has no effect on input pins
// [R14] config registers always read/write; direction resets to all inputs
// [R15] data read gives register bit for outputs, buffered pin for inputs
// [R16] input register always gives buffered pins; writes ignored
// [R17] software keeps direction at input when a timer capture uses the pin
// [R18] a pin flag clears only by writing one to it
// [R19] overrides leave stored direction bits unchanged
module port_r_pin_config (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // avalon-mm slave, word addressed
   input wire logic [port_cfg_pkg::ADDR_WIDTH-1:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [port_cfg_pkg::DATA_WIDTH-1:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   output logic [port_cfg_pkg::DATA_WIDTH-1:0] READDATA,
   output logic WAITREQUEST,
   // interrupt
   output logic IRQ,
   // pads
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE,
   output logic [7:0] PIN_IBUF_EN,
   output logic [7:0] PIN_PULL_ON,
   output logic [7:0] PIN_PULL_DOWN,
   output logic [7:0] PIN_SAMPLE,
   // sharing peripherals
   input wire logic LCD_ENABLE,
   input wire logic I2C_ROUTED,
   input wire logic I2C_ENABLE,
   input wire logic I2C_SCL_OUT,
   input wire logic I2C_SDA_OUT,
   input wire logic SECOND_TIMER_ROUTED,
   input wire logic [1:0] SECOND_TIMER_OC_EN,
   input wire logic [1:0] SECOND_TIMER_OC_OUT,
   input wire logic FIRST_TIMER_ROUTED,
   input wire logic [1:0] FIRST_TIMER_OC_EN,
   input wire logic [1:0] FIRST_TIMER_OC_OUT,
   input wire logic CAN_ROUTED,
   input wire logic CAN_ENABLE,
   input wire logic CAN_TX
);
   import port_cfg_pkg::*;

   // ****************************************
   // bus decode
   // ****************************************
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic request;
   logic accept;
   logic wr_lane;
   logic hit_dir;
   logic hit_pe;
   logic hit_pps;
   logic hit_wom;
   logic hit_data;
   logic hit_input;
   logic hit_status;
   logic hit_clear;
   logic hit_enable;
   logic [7:0] wbyte;

   assign request = READ | WRITE;
   // the answer comes one edge after the request is seen
   assign wait_next = ~(request & wait_reg);
   assign accept = request & ~wait_reg;
   assign wr_lane = WRITE & accept & BYTEENABLE[0];
   assign wbyte = WRITEDATA[7:0];
   assign hit_dir = ADDRESS == IDX_DIRECTION;
   assign hit_pe = ADDRESS == IDX_PULL_ENABLE;
   assign hit_pps = ADDRESS == IDX_PULL_POLARITY;
   assign hit_wom = ADDRESS == IDX_WIRED_OR;
   assign hit_data = ADDRESS == IDX_PORT_DATA;
   assign hit_input = ADDRESS == IDX_PORT_INPUT;
   assign hit_status = ADDRESS == IDX_IRQ_STATUS;
   assign hit_clear = ADDRESS == IDX_IRQ_CLEAR;
   assign hit_enable = ADDRESS == IDX_IRQ_ENABLE;

   // ****************************************
   // configuration registers
   // ****************************************
   logic [7:0] port_direction_reg;
   logic [7:0] port_pull_enable_reg;
   logic [7:0] port_pull_polarity_reg;
   logic [7:0] port_wired_or_mode_reg;
   logic [7:0] port_data_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] pin_buf_reg;
   logic [7:0] pin_interrupt_flags;
   logic [7:0] clear_bits;
   logic [7:0] port_input_reg;
   logic [7:0] data_view;

   assign clear_bits = (wr_lane & hit_clear) ? wbyte : 8'h00; // R18
   // buffered pin state: one register stage after the pads settle
   assign port_input_reg = pin_buf_reg; // R16
   assign data_view = (port_direction_reg & port_data_reg) |
                      (~port_direction_reg & pin_buf_reg); // R15

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (READ & wait_reg) begin
         unique case (1'b1)
            hit_dir: rdata_next[7:0] = port_direction_reg; // R14
            hit_pe: rdata_next[7:0] = port_pull_enable_reg;
            hit_pps: rdata_next[7:0] = port_pull_polarity_reg;
            hit_wom: rdata_next[7:0] = port_wired_or_mode_reg;
            hit_data: rdata_next[7:0] = data_view; // R15
            hit_input: rdata_next[7:0] = port_input_reg; // R16
            hit_status: rdata_next[7:0] = pin_interrupt_flags;
            hit_enable: rdata_next[7:0] = irq_enable_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         port_direction_reg <= RST_DIRECTION; // R14
         port_pull_enable_reg <= RST_PULL_ENABLE; // R9
         port_pull_polarity_reg <= RST_PULL_POLARITY;
         port_wired_or_mode_reg <= RST_WIRED_OR;
         port_data_reg <= RST_PORT_DATA;
         irq_enable_reg <= RST_IRQ_ENABLE;
      end else if (wr_lane) begin
         if (hit_dir) port_direction_reg <= wbyte; // R14
         if (hit_pe) port_pull_enable_reg <= wbyte;
         if (hit_pps) port_pull_polarity_reg <= wbyte;
         if (hit_wom) port_wired_or_mode_reg <= wbyte;
         if (hit_data) port_data_reg <= wbyte;
         if (hit_enable) irq_enable_reg <= wbyte;
      end
   end

   // ****************************************
   // pad resolution
   // ****************************************
   logic [7:0] mux_out;
   logic [7:0] mux_oe;
   logic [7:0] mux_ibuf;
   logic [7:0] mux_pull;
   logic i2c_active;
   logic can_active;
   logic [1:0] timb_active;
   logic [1:0] tima_active;

   assign i2c_active = I2C_ROUTED & I2C_ENABLE; // R3
   assign can_active = CAN_ROUTED & CAN_ENABLE; // R5 R6
   assign timb_active = SECOND_TIMER_OC_EN & {2{SECOND_TIMER_ROUTED}}; // R4
   assign tima_active = FIRST_TIMER_OC_EN & {2{FIRST_TIMER_ROUTED}}; // R5 R6

   port_pin_mux u_mux (
      .dir_bits(port_direction_reg),
      .data_bits(port_data_reg),
      .pull_en_bits(port_pull_enable_reg),
      .wired_or_bits(port_wired_or_mode_reg),
      .lcd_enable(LCD_ENABLE),
      .i2c_active(i2c_active),
      .i2c_out({I2C_SCL_OUT, I2C_SDA_OUT}),
      .timb_oc_active(timb_active),
      .timb_oc_out(SECOND_TIMER_OC_OUT),
      .tima_oc_active(tima_active),
      .tima_oc_out(FIRST_TIMER_OC_OUT),
      .can_active(can_active),
      .can_tx(CAN_TX),
      .pad_out(mux_out),
      .pad_oe(mux_oe),
      .pad_ibuf_en(mux_ibuf),
      .pad_pull_on(mux_pull)
   );

   // ****************************************
   // pad registers and input buffer
   // ****************************************
   // registering the pads and the sample costs one clock each: this is the
   // two-clock settling that software must allow after a direction change
   logic [7:0] pin_out_reg;
   logic [7:0] pin_oe_reg;
   logic [7:0] pin_ibuf_reg;
   logic [7:0] pin_pull_reg;
   logic [7:0] pin_down_reg;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         pin_out_reg <= 8'h00;
         pin_oe_reg <= 8'h00;
         pin_ibuf_reg <= 8'hFF;
         pin_pull_reg <= 8'hFF; // R9
         pin_down_reg <= 8'h00;
         pin_buf_reg <= 8'h00;
      end else begin
         pin_out_reg <= mux_out;
         pin_oe_reg <= mux_oe; // R1 R7
         pin_ibuf_reg <= mux_ibuf;
         pin_pull_reg <= mux_pull; // R8
         pin_down_reg <= port_pull_polarity_reg; // R10 R11
         pin_buf_reg <= PIN_IN & mux_ibuf; // R7 R2
      end
   end

   // ****************************************
   // edge flags and interrupt
   // ****************************************
   logic irq_reg;

   port_edge_flags u_flags (
      .clock(CLOCK),
      .reset(RESET),
      .pin_now(pin_buf_reg),
      .polarity_bits(port_pull_polarity_reg),
      .clear_bits(clear_bits),
      .flags(pin_interrupt_flags)
   );

   always_ff @(posedge CLOCK) begin
      if (RESET) irq_reg <= 1'b0;
      else irq_reg <= |(pin_interrupt_flags & irq_enable_reg);
   end

   assign READDATA = rdata_reg;
   assign WAITREQUEST = wait_reg;
   assign IRQ = irq_reg;
   assign PIN_OUT = pin_out_reg;
   assign PIN_OE = pin_oe_reg;
   assign PIN_IBUF_EN = pin_ibuf_reg;
   assign PIN_PULL_ON = pin_pull_reg;
   assign PIN_PULL_DOWN = pin_down_reg;
   assign PIN_SAMPLE = pin_buf_reg;

   // ****************************************
   // checks
   // ****************************************
   sequence dir_write_s;
      wr_lane && hit_dir;
   endsequence

   sequence pads_follow_s;
      ##1 1'b1 ##1 1'b1;
   endsequence

   dir_drive_a: assert property (@(posedge CLOCK) disable iff (RESET) // R1
      (dir_write_s and (!LCD_ENABLE && !i2c_active && timb_active == 2'b00 &&
       tima_active == 2'b00 && !can_active && port_wired_or_mode_reg == 8'h00))
      ##1 ($stable(LCD_ENABLE) && !i2c_active && timb_active == 2'b00 &&
           tima_active == 2'b00 && !can_active)
      |=> PIN_OE == $past(port_direction_reg))
      else $error("pad enable does not follow direction");

   lcd_off_a: assert property (@(posedge CLOCK) disable iff (RESET) // R2
      LCD_ENABLE |=> (PIN_OE[7:4] == 4'h0 && PIN_IBUF_EN[7:4] == 4'h0 &&
                      PIN_PULL_ON[7:4] == 4'h0))
      else $error("lcd pins not released");

   i2c_od_a: assert property (@(posedge CLOCK) disable iff (RESET) // R3
      (!LCD_ENABLE && i2c_active) |=> (PIN_OUT[6:5] == 2'b00 &&
         PIN_OE[6:5] == ~$past({I2C_SCL_OUT, I2C_SDA_OUT})))
      else $error("i2c pins not open drain");

   timb_out_a: assert property (@(posedge CLOCK) disable iff (RESET) // R4
      (timb_active == 2'b11 && port_wired_or_mode_reg[3:2] == 2'b00)
      |=> (PIN_OE[3:2] == 2'b11 && PIN_OUT[3:2] == $past(SECOND_TIMER_OC_OUT)))
      else $error("second timer compare not driven");

   can_tx_a: assert property (@(posedge CLOCK) disable iff (RESET) // R5
      (can_active && !tima_active[1] && !port_wired_or_mode_reg[1])
      |=> (PIN_OE[1] && PIN_OUT[1] == $past(CAN_TX)))
      else $error("can transmit pin not driven");

   can_rx_a: assert property (@(posedge CLOCK) disable iff (RESET) // R6
      (can_active && !tima_active[0]) |=> !PIN_OE[0])
      else $error("can receive pin not an input");

   settle_read_a: assert property (@(posedge CLOCK) disable iff (RESET) // R7
      (!port_direction_reg[0] && !LCD_ENABLE && !tima_active[0] && $stable(PIN_IN[0]))
      ##1 (!port_direction_reg[0] && $stable(PIN_IN[0]))
      |-> pin_buf_reg[0] == PIN_IN[0])
      else $error("input read not settled in two clocks");

   pull_input_a: assert property (@(posedge CLOCK) disable iff (RESET) // R8
      PIN_OE != 8'h00 |-> (PIN_PULL_ON & PIN_OE) == 8'h00 || $changed(PIN_OE))
      else $error("pull active on driven pin");

   pull_reset_a: assert property (@(posedge CLOCK) // R9
      $fell(RESET) |-> PIN_PULL_ON == 8'hFF && port_pull_enable_reg == 8'hFF)
      else $error("pulls not enabled after reset");

   rise_flag_a: assert property (@(posedge CLOCK) disable iff (RESET) // R10
      (port_pull_polarity_reg[0] && $rose(pin_buf_reg[0])) |=> pin_interrupt_flags[0])
      else $error("rising edge lost");

   fall_flag_a: assert property (@(posedge CLOCK) disable iff (RESET) // R11
      (!port_pull_polarity_reg[0] && $fell(pin_buf_reg[0])) |=> pin_interrupt_flags[0])
      else $error("falling edge lost");

   wired_or_a: assert property (@(posedge CLOCK) disable iff (RESET) // R12
      (port_wired_or_mode_reg[7] && !LCD_ENABLE) |=> !(PIN_OE[7] && PIN_OUT[7]))
      else $error("open drain pin drove high");

   dir_keep_a: assert property (@(posedge CLOCK) disable iff (RESET) // R19
      !(wr_lane && hit_dir) |=> port_direction_reg == $past(port_direction_reg))
      else $error("direction changed without a write");

   flag_clear_a: assert property (@(posedge CLOCK) disable iff (RESET) // R18
      (pin_interrupt_flags[2] && !clear_bits[2]) |=> pin_interrupt_flags[2])
      else $error("flag cleared without a one written");

   bus_answer_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (request && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
      else $error("bus answer not one clock after request");
endmodule

// [pad_world.sv]
// pad and outside-world model for the eight port pins
module pad_world (
   // clock
   input wire logic clock,
   // pad controls from the block
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pull_on,
   input wire logic [7:0] pin_pull_down,
   // outside drivers
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_level,
   // resolved pin level
   output logic [7:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last_reg = 8'h00;
   // a floating pin flips every cycle so a stale level never reads as valid
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i])
            pin_level[i] = pin_out[i];
         else if (ext_en[i])
            pin_level[i] = ext_level[i];
         else if (pin_pull_on[i])
            pin_level[i] = ~pin_pull_down[i];
         else
            pin_level[i] = ~last_reg[i];
      end
   end
   always @(posedge clock) last_reg <= pin_level;
endmodule

// [tb.sv]
// self-checking bench for the port configuration block
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb;
   import port_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, waitreq, irq;
   logic [9:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] be = 4'h1;
   logic [7:0] pin_in, p_out, p_oe, p_ibuf, p_pull, p_pdn, p_smp;
   logic [7:0] ext_en = 8'h00, ext_lv = 8'h00;
   // peripheral inputs packed: lcd, i2c, second timer, first timer, can
   logic [17:0] pv = '0;
   int bad_count = 0, checks_done = 0, cyc = 0, seed = 83279;
   port_r_pin_config DUT (.CLOCK(clock), .RESET(reset), .ADDRESS(addr), .READ(rd),
      .WRITE(wr), .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata),
      .WAITREQUEST(waitreq), .IRQ(irq), .PIN_IN(pin_in), .PIN_OUT(p_out), .PIN_OE(p_oe),
      .PIN_IBUF_EN(p_ibuf), .PIN_PULL_ON(p_pull), .PIN_PULL_DOWN(p_pdn), .PIN_SAMPLE(p_smp),
      .LCD_ENABLE(pv[0]), .I2C_ROUTED(pv[1]), .I2C_ENABLE(pv[2]), .I2C_SCL_OUT(pv[3]),
      .I2C_SDA_OUT(pv[4]), .SECOND_TIMER_ROUTED(pv[5]), .SECOND_TIMER_OC_EN(pv[7:6]),
      .SECOND_TIMER_OC_OUT(pv[9:8]), .FIRST_TIMER_ROUTED(pv[10]),
      .FIRST_TIMER_OC_EN(pv[12:11]), .FIRST_TIMER_OC_OUT(pv[14:13]), .CAN_ROUTED(pv[15]),
      .CAN_ENABLE(pv[16]), .CAN_TX(pv[17]));
   pad_world world (.clock(clock), .pin_out(p_out), .pin_oe(p_oe), .pin_pull_on(p_pull),
      .pin_pull_down(p_pdn), .ext_en(ext_en), .ext_level(ext_lv), .pin_level(pin_in));
   // *****
   // bus tasks and expectations
   // *****
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clock);
      addr <= a;
      wdata <= {24'h00_0000, d};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clock);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20)
         bad_count++;
   endtask
   task automatic wreg(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rchk(input string n, input logic [9:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK(n, e, q)
   endtask
   // pins operating as outputs, before open-drain release of high levels
   function automatic logic [7:0] f_drv(logic [7:0] d, logic [17:0] p);
      logic [7:0] o;
      o = d;
      if (p[0])
         o[7:4] = 4'h0;
      else if (p[1] && p[2])
         o[6:5] = 2'b11;
      if (p[5])
         o[3:2] = o[3:2] | p[7:6];
      if ((p[10] && p[12]) || (p[15] && p[16]))
         o[1] = 1'b1;
      if (p[10] && p[11])
         o[0] = 1'b1;
      else if (p[15] && p[16])
         o[0] = 1'b0;
      return o;
   endfunction
   function automatic logic [7:0] f_oe(logic [7:0] d, t, w, logic [17:0] p);
      logic [7:0] v, od;
      v = t;
      od = w;
      if (!p[0] && p[1] && p[2]) begin
         v[6:5] = {p[3], p[4]};
         od[6:5] = 2'b11;
      end
      if (p[5] && p[6])
         v[2] = p[8];
      if (p[5] && p[7])
         v[3] = p[9];
      if (p[10] && p[12])
         v[1] = p[14];
      else if (p[15] && p[16])
         v[1] = p[17];
      if (p[10] && p[11])
         v[0] = p[13];
      return f_drv(d, p) & ~(od & v);
   endfunction
   function automatic logic [7:0] f_fl(logic [7:0] s, a, b);
      return (s & ~a & b) | (~s & a & ~b);
   endfunction
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc > 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // *****
   // main sequence
   // *****
   initial begin
      logic [7:0] d, t, u, s, w, o, lv, q, fl, en;
      logic [17:0] p;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rchk("direction reset", IDX_DIRECTION, 8'h00);
      rchk("pull reset", IDX_PULL_ENABLE, 8'hFF);
      rchk("polarity reset", IDX_PULL_POLARITY, 8'h00);
      rchk("wired-or reset", IDX_WIRED_OR, 8'h00);
      `CHK("reset enable", 8'h00, p_oe)
      `CHK("reset pull", 8'hFF, p_pull)
      for (int i = 0; i < 32; i++) begin
         {d, t, u, s} = $random(seed);
         w = 8'($random(seed));
         lv = 8'($random(seed));
         p = (i % 2 == 0) ? 18'h0_0000 : 18'($random(seed));
         if (i == 1)
            p = 18'h0_0006;
         // can on pins 1:0 with both second timer compares on pins 3:2
         if (i == 3)
            p = 18'h1_80E0;
         // push-pull on these passes so the timer and can transmit checks can fire
         if (i == 1 || i == 3)
            w = 8'h00;
         o = f_oe(d, t, w, p);
         pv <= p;
         ext_en <= ~o;
         ext_lv <= lv;
         wreg(IDX_DIRECTION, d);
         wreg(IDX_PORT_DATA, t);
         wreg(IDX_PULL_ENABLE, u);
         wreg(IDX_PULL_POLARITY, s);
         wreg(IDX_WIRED_OR, w);
         repeat (SETTLE_CYCLES + 2) @(posedge clock);
         `CHK("pad enable", o, p_oe)
         `CHK("pull on", u & ~f_drv(d, p) & (p[0] ? 8'h0F : 8'hFF), p_pull)
         `CHK("pull down", s, p_pdn)
         `CHK("input buffers", p[0] ? 8'h0F : 8'hFF, p_ibuf)
         rchk("direction kept", IDX_DIRECTION, d);
         if (p == 18'h0_0000) begin
            `CHK("pad out", t & ~w, p_out)
            rchk("data read", IDX_PORT_DATA, (d & t) | (~d & lv));
            wreg(IDX_PORT_INPUT, ~lv);
            rchk("input read", IDX_PORT_INPUT, (o & t) | (~o & lv));
            `CHK("pin sample", (o & t) | (~o & lv), p_smp)
         end
      end
      pv <= '0;
      wreg(IDX_DIRECTION, 8'h00);
      s = 8'($random(seed));
      en = 8'($random(seed));
      wreg(IDX_PULL_POLARITY, s);
      wreg(IDX_IRQ_ENABLE, en);
      lv = 8'h0F;
      ext_en <= 8'hFF;
      ext_lv <= lv;
      repeat (4) @(posedge clock);
      wreg(IDX_IRQ_CLEAR, 8'hFF);
      fl = 8'h00;
      for (int i = 0; i < 6; i++) begin
         q = (i == 0) ? ~lv : 8'($random(seed));
         ext_lv <= q;
         fl = fl | f_fl(s, lv, q);
         lv = q;
         repeat (4) @(posedge clock);
         rchk("edge flags", IDX_IRQ_STATUS, fl);
         `CHK("interrupt", |(fl & en), irq)
      end
      wreg(IDX_IRQ_CLEAR, 8'h00);
      rchk("clear with zero", IDX_IRQ_STATUS, fl);
      q = 8'($random(seed));
      wreg(IDX_IRQ_CLEAR, q);
      rchk("clear with one", IDX_IRQ_STATUS, fl & ~q);
      wreg(IDX_IRQ_CLEAR, 8'hFF);
      repeat (2) @(posedge clock);
      `CHK("interrupt cleared", 1'b0, irq)
      rchk("unmapped read", 10'h3FF, 8'h00);
      wreg(10'h3FF, 8'hFF);
      be <= 4'h0;
      wreg(IDX_DIRECTION, 8'hFF);
      be <= 4'h1;
      rchk("byte enable off", IDX_DIRECTION, 8'h00);
      wreg(IDX_DIRECTION, 8'hFF);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rchk("direction after reset", IDX_DIRECTION, 8'h00);
      `CHK("pull after reset", 8'hFF, p_pull)
      complete_run();
   end
endmodule
